// ### logic/dpram_host_pkg.sv
// Constants, timing figures and carrier types for the dual-port memory port host
package dpram_host_pkg;

    // ========================================================================
    // Clock and timing figures (ns, one speed grade)
    localparam int CLK_MHZ    = 50;
    localparam int TWP_NS     = 15;   // Write pulse width
    localparam int TDW_NS     = 15;   // Data valid to end of write
    localparam int TWZ_NS     = 10;   // Write enable to output high-Z
    localparam int TAA_NS     = 20;   // Address access
    localparam int TACE_NS    = 20;   // Port select access
    localparam int TAOE_NS    = 12;   // Output enable access
    localparam int TSAA_NS    = 20;   // Flag address access
    localparam int HOLD_RELEASE_TO_DATA_DELAY_NS    = 35;   // Hold release to valid data
    localparam int TSWRD_NS   = 5;    // Flag write to read
    localparam int TSOP_NS    = 10;   // Flag update pulse

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // Least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        return max2(1, (ns * CLK_MHZ + 999) / 1000);
    endfunction

    // Output enable stays high in writes, so the turn-off term is kept only as a bound
    localparam int WR_OE_LOW_NS  = max2(TWP_NS, TWZ_NS + TDW_NS);
    localparam int WR_OE_HIGH_NS = max2(TWP_NS, TDW_NS);
    localparam int WR_PULSE_CYC  = ns_to_cyc(WR_OE_HIGH_NS);
    localparam int RD_ACC_CYC    = ns_to_cyc(max2(max2(TAA_NS, TACE_NS),
                                                  max2(TAOE_NS, TSAA_NS)));
    localparam int RD_HOLD_CYC   = ns_to_cyc(HOLD_RELEASE_TO_DATA_DELAY_NS);
    localparam int GAP_CYC       = ns_to_cyc(max2(TSWRD_NS, TSOP_NS));

    // ========================================================================
    // Widths and encodings
    localparam int ADDR_W    = 15;
    localparam int DATA_W    = 16;
    localparam int CNT_W     = 4;
    localparam int FLAG_AW   = 3;     // Eight flags on the lowest address lines

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETUP   = 3'b001,
        ST_STROBE  = 3'b011,
        ST_RECOVER = 3'b010,
        ST_READ    = 3'b101
    } host_state_t;

    typedef struct packed {
        logic              write;
        logic              flag;       // 1: semaphore flag, 0: array
        logic              upper_en;
        logic              lower_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } host_cmd_t;

    typedef struct packed {
        logic              port_select_n;
        logic              flag_select_n;
        logic              write_not_read;
        logic              out_en_n;
        logic              upper_byte_select_n;
        logic              lower_byte_select_n;
        logic [ADDR_W-1:0] addr;
    } port_ctrl_t;

    localparam port_ctrl_t CTRL_IDLE = '{
        port_select_n: 1'b1, flag_select_n: 1'b1, write_not_read: 1'b1,
        out_en_n: 1'b1, upper_byte_select_n: 1'b1, lower_byte_select_n: 1'b1,
        addr: 15'h0000};

endpackage

// ### logic/dpram_port_host.sv
// Host controller driving one port of an asynchronous dual-port memory
`timescale 1ns/1ps

// Operation
// - Select combination stays valid from assertion through end of write.
// - Address only changes while write_not_read and port select are high.
// - Write pulse covers minimum width and data set-up; output enable stays high, so no turn-off term.
// - Host drives data only while device outputs are disabled.
// - Flag write then read keeps port select and both byte selects high.
module dpram_port_host
    import dpram_host_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              cmd_valid,
    input  wire host_cmd_t         cmd,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output port_ctrl_t             port_ctrl,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              hold_n
);

    // ========================================================================
    // State
    host_state_t       state_r;
    host_state_t       state_nxt;
    host_cmd_t         cmd_r;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic              held_r;
    port_ctrl_t        ctrl_nxt;

    // ========================================================================
    // Decode
    // Taken only with ready seen high; the first cycle after reset is never a take
    wire               take_cmd   = cmd_ready && cmd_valid;
    wire               cnt_done   = (cnt_r == CNT_ZERO);
    wire               is_flag    = cmd_r.flag;
    // Flags only look at the low address lines; the rest are parked at zero
    wire [ADDR_W-1:0]  flag_addr  = {{(ADDR_W-FLAG_AW){1'b0}}, cmd.addr[FLAG_AW-1:0]};
    wire [ADDR_W-1:0]  next_addr  = cmd.flag ? flag_addr : cmd.addr;
    // Write data: a flag write carries its value on bit zero only
    wire [DATA_W-1:0]  wr_word    = is_flag ? {{(DATA_W-1){1'b0}}, cmd_r.wdata[0]}
                                            : cmd_r.wdata;
    // Only bit zero of a flag read is used; a low value means this port holds the token; fan the value out
    wire               flag_bit   = data_in[0];
    wire [DATA_W-1:0]  rd_word    = is_flag ? {DATA_W{flag_bit}} : data_in;
    wire               read_hold  = !hold_n && !is_flag;
    wire               hold_seen  = held_r || read_hold;

    // ========================================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_done ? CNT_ZERO : cnt_r - 4'h1;
        ctrl_nxt  = port_ctrl;
        case (state_r)
            ST_IDLE: begin
                if (take_cmd) begin
                    state_nxt = ST_SETUP;
                    // Address moves only here, with every select high
                    ctrl_nxt      = CTRL_IDLE;
                    ctrl_nxt.addr = next_addr;
                    // Array: port select low; flags: flag select low, port select high
                    ctrl_nxt.port_select_n = cmd.flag;
                    ctrl_nxt.flag_select_n = !cmd.flag;
                    // Flag access keeps both byte selects high as well
                    ctrl_nxt.upper_byte_select_n = cmd.flag || !cmd.upper_en;
                    ctrl_nxt.lower_byte_select_n = cmd.flag || !cmd.lower_en;
                    ctrl_nxt.out_en_n = cmd.write;
                end
            end
            ST_SETUP: begin
                if (cmd_r.write) begin
                    // Selects already low one cycle before the strobe
                    state_nxt = ST_STROBE;
                    ctrl_nxt.write_not_read = 1'b0;
                    cnt_nxt   = CNT_W'(WR_PULSE_CYC - 1);
                end else begin
                    state_nxt = ST_READ;
                    cnt_nxt   = CNT_W'(RD_ACC_CYC - 1);
                end
            end
            ST_STROBE: begin
                // A refused write is stretched until the hold input releases
                if (cnt_done && hold_n) begin
                    state_nxt = ST_RECOVER;
                    // Strobe ends first; selects stay for recovery and data hold
                    ctrl_nxt.write_not_read = 1'b1;
                end
            end
            ST_RECOVER: begin
                state_nxt = ST_IDLE;
                ctrl_nxt  = CTRL_IDLE;
                ctrl_nxt.addr = port_ctrl.addr;
                cnt_nxt   = CNT_W'(GAP_CYC - 1);
            end
            ST_READ: begin
                if (read_hold) begin
                    // Opposite port completing a write here; restart the wait
                    cnt_nxt = CNT_W'(RD_HOLD_CYC - 1);
                end else if (cnt_done) begin
                    state_nxt = ST_IDLE;
                    ctrl_nxt  = CTRL_IDLE;
                    ctrl_nxt.addr = port_ctrl.addr;
                    cnt_nxt   = CNT_W'(GAP_CYC - 1);
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ctrl_nxt  = CTRL_IDLE;
                cnt_nxt   = CNT_ZERO;
            end
        endcase
    end

    // ========================================================================
    // Registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r   <= ST_IDLE;
            cnt_r     <= CNT_ZERO;
            port_ctrl <= CTRL_IDLE;
            cmd_r     <= '0;
            held_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            port_ctrl <= ctrl_nxt;
            held_r    <= (state_r == ST_READ) ? hold_seen : 1'b0;
            if (take_cmd) begin
                cmd_r <= cmd;
            end
        end
    end

    // Data drive only in strobe and recovery, where outputs are disabled
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_oe  <= 1'b0;
            data_out <= 16'h0000;
        end else begin
            data_oe  <= (state_nxt == ST_STROBE) || (state_nxt == ST_RECOVER);
            data_out <= wr_word;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 16'h0000;
            cmd_ready <= 1'b0;
        end else begin
            rsp_valid <= (state_r == ST_READ) && !read_hold && cnt_done;
            if ((state_r == ST_READ) && !read_hold && cnt_done) begin
                rsp_data <= rd_word;
            end
            // Flag writes may race the other port; software re-reads to learn the owner
            cmd_ready <= (state_nxt == ST_IDLE) && (cnt_nxt == CNT_ZERO) && !take_cmd;
        end
    end

endmodule // dpram_port_host

// ### verification/dpram_port_host_properties.sv
// Pin protocol assertions for the dual-port memory host
`timescale 1ns/1ps
// ==========================================================================
// Checker
module dpram_port_host_properties
    import dpram_host_pkg::*;
(
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic              rsp_valid,
    input wire port_ctrl_t        port_ctrl,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              data_oe,
    input wire logic              hold_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire       wnr  = port_ctrl.write_not_read;
    wire       oen  = port_ctrl.out_en_n;
    wire [1:0] sel  = {port_ctrl.port_select_n, port_ctrl.flag_select_n};
    wire       bsel = port_ctrl.upper_byte_select_n && port_ctrl.lower_byte_select_n;
    property p_decode; sel != 2'b00; endproperty
    a_decode: assert property (p_decode) else $error("both selects low");
    property p_sel_hold; !wnr |-> $stable(sel) ##1 $stable(sel); endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved in write");
    property p_addr;
        $changed(port_ctrl.addr) |-> wnr && $past(wnr) && (sel == 2'b11 || $past(sel) == 2'b11);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved while active");
    property p_we_sel; !wnr |-> sel != 2'b11; endproperty
    a_we_sel: assert property (p_we_sel) else $error("strobe without select");
    property p_we_late; $fell(wnr) |-> $past(sel) != 2'b11 && oen; endproperty
    a_we_late: assert property (p_we_late) else $error("strobe before select");
    property p_strobe; !wnr |-> data_oe && oen; endproperty
    a_strobe: assert property (p_strobe) else $error("data idle in strobe");
    property p_flag_pins; sel == 2'b10 |-> bsel; endproperty
    a_flag_pins: assert property (p_flag_pins) else $error("byte select in flag");
    property p_flag_bit; sel == 2'b10 && data_oe |-> data_out[15:1] == 15'h0000; endproperty
    a_flag_bit: assert property (p_flag_bit) else $error("flag write upper bits");
    property p_rd_acc; rsp_valid |-> !$past(oen) && !$past(oen, 2); endproperty
    a_rd_acc: assert property (p_rd_acc) else $error("read sampled early");
    property p_rd_fast; $fell(oen) && hold_n ##1 hold_n ##1 hold_n |-> rsp_valid; endproperty
    a_rd_fast: assert property (p_rd_fast) else $error("read delayed without hold");
    c_flag_rd: cover property (sel == 2'b10 && !oen);
    c_arr_wr: cover property ($fell(wnr) && sel == 2'b01);
    c_hold_rd: cover property (!oen && !hold_n);
endmodule // dpram_port_host_properties

bind dpram_port_host dpram_port_host_properties u_props (.clock, .sys_rst, .rsp_valid,
    .port_ctrl, .data_out, .data_oe, .hold_n);

// ### verification/dpram_model.sv
// Behavioural model of one port of the dual-port memory device
`timescale 1ns/1ps
// ==========================================================================
// Array, flags and data pins
module dpram_model
    import dpram_host_pkg::*;
(
    input  wire logic              clock,
    input  wire port_ctrl_t        ctrl,
    input  wire logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0]      data_in
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0]        flag_r = 8'hff;
    logic              wnr_r  = 1'b1;
    logic [DATA_W-1:0] last_r = 16'h0000;
    wire arr = !ctrl.port_select_n && ctrl.flag_select_n;
    wire flg = ctrl.port_select_n && !ctrl.flag_select_n;
    wire rd  = ctrl.write_not_read && !ctrl.out_en_n;
    // Released pins flip each cycle so a stale level never passes
    assign data_in = (rd && flg) ? {DATA_W{flag_r[ctrl.addr[2:0]]}} :
                     (rd && arr) ? mem[ctrl.addr] : ~last_r;
    always @(posedge clock) begin
        last_r <= data_in;
        wnr_r  <= ctrl.write_not_read;
        if (!ctrl.write_not_read && arr && !ctrl.upper_byte_select_n)
            mem[ctrl.addr][15:8] <= data_out[15:8];
        if (!ctrl.write_not_read && arr && !ctrl.lower_byte_select_n)
            mem[ctrl.addr][7:0] <= data_out[7:0];
        // Lone port: no rival, so a free flag is always granted
        if (!wnr_r && ctrl.write_not_read && flg)
            flag_r[ctrl.addr[2:0]] <= data_out[0];
    end
endmodule // dpram_model

// ### verification/dpram_port_host_tb.sv
// Self-checking bench for the dual-port memory host controller
`timescale 1ns/1ps
// ==========================================================================
// Stimulus, scoreboard and verdict
module dpram_port_host_tb
    import dpram_host_pkg::*;
;
    logic              clock     = 1'b0;
    logic              sys_rst   = 1'b1;
    logic              cmd_valid = 1'b0;
    host_cmd_t         cmd       = '0;
    logic              hold_n    = 1'b1;
    logic              cmd_ready, rsp_valid, data_oe, u, l;
    logic [DATA_W-1:0] rsp_data, data_out, data_in, d;
    port_ctrl_t        port_ctrl;
    logic [ADDR_W-1:0] a;
    int                num_errors  = 0;
    int                comparisons = 0;
    int                seed        = 32'h90924e97;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
    logic [7:0]        flags = 8'hff;
    dpram_port_host u_dut (.clock, .sys_rst, .cmd_valid, .cmd, .cmd_ready, .rsp_valid,
        .rsp_data, .port_ctrl, .data_out, .data_oe, .data_in, .hold_n);
    dpram_model u_dev (.clock, .ctrl(port_ctrl), .data_out, .data_in);
    initial forever #10 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until the edge that sees ready; refused cycles are not queued
    task automatic send(input logic w, f, uu, ll, input logic [ADDR_W-1:0] ad,
                        input logic [DATA_W-1:0] wd);
        int n;
        n = 0;
        cmd <= '{w, f, uu, ll, ad, wd};
        cmd_valid <= 1'b1;
        @(posedge clock);
        while (cmd_ready !== 1'b1 && n < 40) begin
            n++;
            @(posedge clock);
        end
        if (cmd_ready !== 1'b1) num_errors++;
        cmd_valid <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic f, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        send(1'b0, f, 1'b1, 1'b1, ad, 16'h0000);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) hold_n <= ($random(seed) & 3) != 0;
    always @(posedge clock) begin
        if (rsp_valid === 1'b1)
            check(32'(rsp_data), 32'(exp_q.pop_front()));
    end
    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clock);
        check(32'(port_ctrl), 32'(CTRL_IDLE));
        sys_rst <= 1'b0;
        // Take every flag, then release it; upper address bits must not matter
        for (int i = 0; i < 16; i++) begin
            send(1'b1, 1'b1, 1'b1, 1'b1, {12'($random(seed)), 3'(i)}, {15'($random(seed)), i[3]});
            flags[i[2:0]] = i[3];
            rd(1'b1, {12'($random(seed)), 3'(i)}, {DATA_W{flags[i[2:0]]}});
        end
        for (int i = 0; i < 24; i++) begin
            a = 15'($random(seed));
            d = 16'($random(seed));
            send(1'b1, 1'b0, 1'b1, 1'b1, a, d);
            shadow[a] = d;
            d = 16'($random(seed));
            u = 1'($random(seed));
            l = 1'($random(seed));
            send(1'b1, 1'b0, u, l, a, d);
            if (u) shadow[a][15:8] = d[15:8];
            if (l) shadow[a][7:0] = d[7:0];
            rd(1'b0, a, shadow[a]);
            rd(1'b0, a, shadow[a]);
        end
        repeat (8) @(posedge clock);
        check(32'(exp_q.size()), 32'h0000_0000);
        finish_test();
    end
endmodule // dpram_port_host_tb
